// ---- hw/aux_top.sv ----
// Notes on behaviour
// - Duty period is interval times 4*2^exp/32768 s
// - Duty wake sends buffered packet unprompted
// - Packet sent pulls irq if enabled
// - After sending, return to wake state
// - Read command 0x14, enable byte, config
// - Enable bits 1:0 choose pin, input
// - Disabled measurement returns zero
// - Reply: ready, pin, battery, temp, reserved
// - Temperature code scaled 568/2560 minus 297
// - Battery volts are three code over 1280
// - Pin volts are code over divisor
// - Upper nibble sets time; zero byte gives 0xC
// - Lower nibble attenuation; zero byte gives 0xC
// - Supply check only with wake timer on
// - Each wake expiry compares supply threshold
// - Threshold steps 50 mV, 1.5 to 3.05
// - Low supply to irq or pin
// - Any enabled event pulls irq low
// - Shutdown high clears all but the input sample stages
// - Wake period mantissa times 4*2^exp/32768
// - Duty field two acts as transmit start
module aux_top
  import aux_pkg::*;
(
  // Clock and shutdown (acts as synchronous reset)
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // 32 kHz tick enable for wake timing
  input  wire logic        i_tick_32k,
  // Wake configuration
  input  wire logic        i_wake_enable,
  input  wire logic        i_low_supply_check_en,
  input  wire logic [1:0]  i_duty_mode,
  input  wire logic [4:0]  i_wake_exponent,
  input  wire logic [15:0] i_wake_mantissa,
  input  wire logic [15:0] i_duty_interval_count,
  input  wire logic [4:0]  i_low_supply_threshold,
  input  wire logic        i_low_supply_to_pin,
  // Interrupt enables
  input  wire logic        i_irq_en_sent,
  input  wire logic        i_irq_en_wake,
  input  wire logic        i_irq_en_low_supply,
  input  wire logic        i_irq_status_clear,
  // Transmit path handshake
  output logic             o_tx_start,
  input  wire logic        i_tx_done,
  // Command byte stream from host
  input  wire logic        i_cmd_valid,
  input  wire logic [7:0]  i_cmd_byte,
  output logic             o_cmd_ready,
  // Reply byte stream to host
  output logic             o_rsp_valid,
  output logic [7:0]       o_rsp_byte,
  input  wire logic        i_rsp_ready,
  // Analog front end samples (from pins, resynchronised)
  input  wire logic [15:0] i_raw_pin,
  input  wire logic [15:0] i_raw_batt,
  input  wire logic [15:0] i_raw_temp,
  // Converter settings seen by front end
  output logic [1:0]       o_pin_select,
  output logic [3:0]       o_pin_input_attenuation,
  // Status outputs
  output logic             o_irq_out_n,
  output logic             o_low_supply_pin,
  output logic [2:0]       o_irq_status,
  output logic             o_in_wake_state
);

  typedef enum logic [3:0] {
    AUX_ST_IDLE = 4'b0001,
    AUX_ST_ARGS = 4'b0010,
    AUX_ST_CONV = 4'b0100,
    AUX_ST_RPLY = 4'b1000
  } aux_cmd_st_t;

  typedef enum logic [2:0] {
    AUX_DS_OFF  = 3'b001,
    AUX_DS_WAKE = 3'b010,
    AUX_DS_TX   = 3'b100
  } aux_duty_st_t;

  // Constants the logic relies on; refuse a mismatched package
  if (AUX_REPLY_BYTES > 16) begin : g_reply_chk
    $error("aux_top: reply does not fit the byte index");
  end
  if (AUX_THR_MIN_MV + AUX_THR_STEP_MV * int'(AUX_THR_MAX_CODE)
      != AUX_THR_MAX_MV) begin : g_thr_chk
    $error("aux_top: threshold range and code width disagree");
  end

  // Raw samples come from the analog side: two stages first.
  // Held words only; a sample moving mid-capture may tear.
  logic [15:0] pin_s1_q, pin_s2_q;
  logic [15:0] batt_s1_q, batt_s2_q;
  logic [15:0] temp_s1_q, temp_s2_q;

  always_ff @(posedge i_clk) begin
    pin_s1_q  <= i_raw_pin;
    pin_s2_q  <= pin_s1_q;
    batt_s1_q <= i_raw_batt;
    batt_s2_q <= batt_s1_q;
    temp_s1_q <= i_raw_temp;
    temp_s2_q <= temp_s1_q;
  end

  // Wake timer and duty-cycle timer share one exponent
  wire wake_run = i_wake_enable;
  wire duty_run = i_wake_enable && (i_duty_mode == AUX_DUTY_TX);
  wire wake_exp;
  wire duty_exp;

  aux_wake u_wake (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_run      (wake_run),
    .i_tick     (i_tick_32k),
    .i_exponent (i_wake_exponent),
    .i_count    (i_wake_mantissa),
    .o_expire   (wake_exp)
  );

  aux_wake u_duty (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_run      (duty_run),
    .i_tick     (i_tick_32k),
    .i_exponent (i_wake_exponent),
    .i_count    (i_duty_interval_count),
    .o_expire   (duty_exp)
  );

  // Duty-cycle sequencer
  aux_duty_st_t ds_q, ds_d;
  logic         sent_pulse;

  always_comb begin
    ds_d       = ds_q;
    sent_pulse = 1'b0;
    unique case (ds_q)
      AUX_DS_OFF:  if (duty_run) ds_d = AUX_DS_WAKE;
      AUX_DS_WAKE: begin
        if (!duty_run) ds_d = AUX_DS_OFF;
        else if (duty_exp) ds_d = AUX_DS_TX;
      end
      AUX_DS_TX: begin
        if (i_tx_done) begin
          ds_d       = duty_run ? AUX_DS_WAKE : AUX_DS_OFF;
          sent_pulse = 1'b1;
        end
      end
      default: ds_d = AUX_DS_OFF;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) ds_q <= AUX_DS_OFF;
    else        ds_q <= ds_d;
  end

  // Send request is combinational so it meets the expiry pulse
  wire ds_wake = (ds_q == AUX_DS_WAKE);
  assign o_tx_start      = ds_wake && duty_run && duty_exp;
  assign o_in_wake_state = ds_wake;

  // Low supply compare on each wake expiry
  wire [15:0] thr_step = 16'(AUX_THR_STEP_MV)
                       * 16'(i_low_supply_threshold);
  wire [15:0] thr_mv   = 16'(AUX_THR_MIN_MV) + thr_step;
  wire [15:0] batt_mv  = aux_batt_mv(batt_s2_q);
  // Checked only on expiry; a disabled timer never expires
  wire low_check = wake_exp && i_wake_enable
                 && i_low_supply_check_en;
  wire low_hit   = low_check && (batt_mv < thr_mv);

  always_ff @(posedge i_clk) begin
    if (i_srst) o_low_supply_pin <= 1'b0;
    else if (low_check) o_low_supply_pin <= i_low_supply_to_pin && low_hit;
  end

  // Sticky status: set wins over clear
  logic [2:0] stat_q;
  wire        low_irq  = low_hit && !i_low_supply_to_pin;
  wire  [2:0] stat_set = {low_irq, wake_exp, sent_pulse};
  wire  [2:0] stat_en  = {i_irq_en_low_supply, i_irq_en_wake, i_irq_en_sent};
  wire  [2:0] stat_d   = stat_set | (i_irq_status_clear ? 3'h0 : stat_q);

  always_ff @(posedge i_clk) begin
    if (i_srst) stat_q <= 3'h0;
    else stat_q <= stat_d;
  end

  assign o_irq_status = stat_q;

  // Interrupt pin low while any enabled cause pends; it follows the
  // next status so a clear releases the pin in the same cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) o_irq_out_n <= 1'b1;
    else o_irq_out_n <= ~|(stat_en & stat_d);
  end

  // Converter command handler
  aux_cmd_st_t cs_q;
  logic [1:0]  argn_q;
  logic [7:0]  en_q, cfg_q;
  logic [3:0]  ridx_q;
  // A zero configuration byte selects the default time and range
  wire  [7:0]  cfg_eff = (cfg_q == 8'h00) ? AUX_CFG_DEFAULT
                                          : cfg_q;
  wire         conv_busy, conv_done;
  wire  [15:0] res_pin, res_batt, res_temp;
  wire  [2:0]  conv_en = {en_q[AUX_EN_TEMP_BIT], en_q[AUX_EN_BATT_BIT],
                          en_q[AUX_EN_PIN_BIT]};
  logic        conv_go;

  aux_conv u_conv (
    .i_clk      (i_clk),
    .i_srst     (i_srst),
    .i_start    (conv_go),
    .i_time_exp (cfg_eff[7:4]),
    .i_enables  (conv_en),
    .i_raw_pin  (pin_s2_q),
    .i_raw_batt (batt_s2_q),
    .i_raw_temp (temp_s2_q),
    .o_busy     (conv_busy),
    .o_done     (conv_done),
    .o_pin      (res_pin),
    .o_batt     (res_batt),
    .o_temp     (res_temp)
  );

  // State decodes shared by the handshakes
  wire cs_idle = (cs_q == AUX_ST_IDLE);
  wire cs_args = (cs_q == AUX_ST_ARGS);
  wire cs_rply = (cs_q == AUX_ST_RPLY);

  // Commands are refused until the reply drains
  assign o_cmd_ready = cs_idle || cs_args;
  wire cmd_take = i_cmd_valid && o_cmd_ready;

  // Command bytes: only the read code opens a transfer
  always_ff @(posedge i_clk) begin
    conv_go <= 1'b0;
    if (i_srst) begin
      cs_q   <= AUX_ST_IDLE;
      argn_q <= 2'h0;
      en_q   <= 8'h00;
      cfg_q  <= 8'h00;
      ridx_q <= 4'h0;
    end else begin
      unique case (cs_q)
        AUX_ST_IDLE: if (cmd_take && i_cmd_byte == AUX_CMD_CONV_READ) begin
          cs_q   <= AUX_ST_ARGS;
          argn_q <= 2'h0;
        end
        AUX_ST_ARGS: if (cmd_take) begin
          if (argn_q == 2'h0) begin
            en_q   <= i_cmd_byte;
            argn_q <= 2'h1;
          end else begin
            cfg_q   <= i_cmd_byte;
            conv_go <= 1'b1;
            cs_q    <= AUX_ST_CONV;
          end
        end
        AUX_ST_CONV: if (conv_done) begin
          cs_q   <= AUX_ST_RPLY;
          ridx_q <= 4'h0;
        end
        AUX_ST_RPLY: if (i_rsp_ready) begin
          if (ridx_q == 4'(AUX_REPLY_BYTES - 1)) cs_q <= AUX_ST_IDLE;
          else ridx_q <= ridx_q + 4'h1;
        end
        default: cs_q <= AUX_ST_IDLE;
      endcase
    end
  end

  // Front end follows the latched enable and config bytes;
  // unknown attenuation codes pass through unchanged
  assign o_pin_select            = en_q[AUX_EN_PIN_SEL_LSB +: 2];
  assign o_pin_input_attenuation = cfg_eff[3:0];

  // Reply byte order, high byte first
  assign o_rsp_valid = cs_rply;
  always_comb begin
    unique case (ridx_q)
      4'h0:    o_rsp_byte = AUX_CTS_READY;
      4'h1:    o_rsp_byte = res_pin[15:8];
      4'h2:    o_rsp_byte = res_pin[7:0];
      4'h3:    o_rsp_byte = res_batt[15:8];
      4'h4:    o_rsp_byte = res_batt[7:0];
      4'h5:    o_rsp_byte = res_temp[15:8];
      4'h6:    o_rsp_byte = res_temp[7:0];
      default: o_rsp_byte = AUX_RESERVED_BYTE;
    endcase
  end

endmodule

// ---- hw/aux_pkg.sv ----
package aux_pkg;

  // Command codes and byte layout
  localparam logic [7:0] AUX_CMD_CONV_READ  = 8'h14;
  localparam int         AUX_EN_PIN_SEL_LSB = 0;
  localparam int         AUX_EN_PIN_BIT     = 2;
  localparam int         AUX_EN_BATT_BIT    = 3;
  localparam int         AUX_EN_TEMP_BIT    = 4;
  localparam logic [7:0] AUX_CFG_DEFAULT    = 8'hcc;
  localparam logic [7:0] AUX_CTS_READY      = 8'hff;
  localparam logic [7:0] AUX_RESERVED_BYTE  = 8'h00;
  localparam int         AUX_REPLY_BYTES    = 9;

  // Attenuation codes
  localparam logic [3:0] AUX_ATT_0V8 = 4'h0;
  localparam logic [3:0] AUX_ATT_1V6 = 4'h4;
  localparam logic [3:0] AUX_ATT_2V4 = 4'h8;
  localparam logic [3:0] AUX_ATT_3V6 = 4'h9;
  localparam logic [3:0] AUX_ATT_3V2 = 4'hc;

  // Pin result divisors, times 100
  localparam int AUX_DIV_0V8_X100 = 256000;
  localparam int AUX_DIV_1V6_X100 = 128000;
  localparam int AUX_DIV_2V4_X100 = 85333;
  localparam int AUX_DIV_3V6_X100 = 42666;
  localparam int AUX_DIV_3V2_X100 = 64000;

  // Result scaling: Vbatt = 3*code/1280, T = code*568/2560 - 297
  localparam int AUX_BATT_NUM  = 1280;
  localparam int AUX_BATT_DEN  = 3;
  localparam int AUX_TEMP_NUM  = 2560;
  localparam int AUX_TEMP_DEN  = 568;
  localparam int AUX_TEMP_OFS  = 297;

  // Conversion time: 12 * 2^(exp+1) clocks
  localparam int AUX_CONV_DIV  = 12;

  // Wake periods: count * 4 * 2^exp / 32768 s
  localparam int AUX_WAKE_MULT = 4;
  localparam int AUX_WAKE_BASE = 32768;

  // Low supply threshold: 1.5 V plus 50 mV steps up to 3.05 V
  localparam int AUX_THR_MIN_MV  = 1500;
  localparam int AUX_THR_STEP_MV = 50;
  localparam int AUX_THR_MAX_MV  = 3050;
  localparam logic [4:0] AUX_THR_MAX_CODE = 5'h1f;

  // Duty-cycle field value for transmit mode
  localparam logic [1:0] AUX_DUTY_TX = 2'h2;

  // Millivolts of battery code: mv = code*3000/1280
  function automatic logic [15:0] aux_batt_mv(input logic [15:0] code);
    logic [31:0] p;
    p = 32'(code) * 32'(AUX_BATT_DEN * 1000) / 32'(AUX_BATT_NUM);
    // Saturate so a large code never wraps below a threshold
    return (p > 32'h0000ffff) ? 16'hffff : p[15:0];
  endfunction

endpackage

// ---- hw/aux_conv.sv ----
// Converter sequencer: one conversion per enabled input, fixed duration
module aux_conv
  import aux_pkg::*;
#(
  parameter int DIV_W = 24
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // Request
  input  wire logic        i_start,
  input  wire logic [3:0]  i_time_exp,
  input  wire logic [2:0]  i_enables,
  input  wire logic [15:0] i_raw_pin,
  input  wire logic [15:0] i_raw_batt,
  input  wire logic [15:0] i_raw_temp,
  // Results
  output logic             o_busy,
  output logic             o_done,
  output logic [15:0]      o_pin,
  output logic [15:0]      o_batt,
  output logic [15:0]      o_temp
);
  // Longest slot is 12 << 16 clocks; the counter must hold it
  if (DIV_W < 20) begin : g_width_chk
    $error("aux_conv: DIV_W too small");
  end

  logic [DIV_W-1:0] cnt_q;
  logic [2:0]       todo_q;
  logic             busy_q;
  wire  [DIV_W-1:0] conv_len;
  wire  [2:0]       first_bit;

  // Time of one conversion in clocks; at least one cycle
  assign conv_len  = DIV_W'(AUX_CONV_DIV) << (5'(i_time_exp) + 5'h1);
  assign first_bit = todo_q & (~todo_q + 3'h1);
  assign o_busy    = busy_q;

  // Walk the enabled inputs lowest first; skipped ones stay zero
  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_srst) begin
      busy_q <= 1'b0;
      todo_q <= 3'h0;
      cnt_q  <= '0;
      o_pin  <= 16'h0000;
      o_batt <= 16'h0000;
      o_temp <= 16'h0000;
    end else if (!busy_q && i_start) begin
      busy_q <= 1'b1;
      todo_q <= i_enables;
      cnt_q  <= conv_len - DIV_W'(1);
      o_pin  <= 16'h0000;
      o_batt <= 16'h0000;
      o_temp <= 16'h0000;
    end else if (busy_q) begin
      if (todo_q == 3'h0) begin
        busy_q <= 1'b0;
        o_done <= 1'b1;
      end else if (cnt_q == '0) begin
        if (first_bit[0]) o_pin  <= i_raw_pin;
        if (first_bit[1]) o_batt <= i_raw_batt;
        if (first_bit[2]) o_temp <= i_raw_temp;
        todo_q <= todo_q & ~first_bit;
        cnt_q  <= conv_len - DIV_W'(1);
      end else begin
        cnt_q <= cnt_q - DIV_W'(1);
      end
    end
  end
endmodule

// ---- hw/aux_wake.sv ----
// Wake counter: counts 32 kHz ticks to a programmed limit
module aux_wake (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  // Control
  input  wire logic        i_run,
  input  wire logic        i_tick,
  input  wire logic [4:0]  i_exponent,
  input  wire logic [15:0] i_count,
  // Expiry
  output logic             o_expire
);
  // Widest limit: 16-bit count, times 4, shifted by up to 31
  localparam int CNT_W = 49;

  logic [CNT_W-1:0] cnt_q;
  wire  [CNT_W-1:0] limit;

  // count * 4 * 2^exp ticks of the 32768 Hz base
  assign limit = (CNT_W'(i_count) << 2) << i_exponent;

  always_ff @(posedge i_clk) begin
    o_expire <= 1'b0;
    if (i_srst || !i_run || limit == '0) begin
      cnt_q <= '0;
    end else if (i_tick) begin
      if (cnt_q >= limit - CNT_W'(1)) begin
        cnt_q    <= '0;
        o_expire <= 1'b1;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end
endmodule

// ---- sim/aux_top_asserts.sv ----
// Port-level checks beside the auxiliary block
module aux_top_asserts
  import aux_pkg::*;
(
  // Clock and shutdown
  input wire logic       i_clk,
  input wire logic       i_srst,
  // Inputs watched
  input wire logic [1:0] i_duty_mode,
  input wire logic       i_wake_enable,
  input wire logic       i_irq_en_sent,
  input wire logic       i_tx_done,
  input wire logic       i_cmd_valid,
  input wire logic [7:0] i_cmd_byte,
  input wire logic       i_rsp_ready,
  // Outputs watched
  input wire logic       o_cmd_ready,
  input wire logic       o_rsp_valid,
  input wire logic [7:0] o_rsp_byte,
  input wire logic       o_tx_start,
  input wire logic [1:0] o_pin_select,
  input wire logic [3:0] o_pin_input_attenuation,
  input wire logic       o_irq_out_n,
  input wire logic [2:0] o_irq_status,
  input wire logic       o_in_wake_state
);
  logic [1:0] idx_q;
  logic [1:0] idx_d;
  wire        take = i_cmd_valid && o_cmd_ready;
  // Position in the three-byte command; stray first bytes do not count
  assign idx_d = !take ? idx_q : (idx_q == 2'h2) ? 2'h0 :
    (idx_q != 2'h0 || i_cmd_byte == AUX_CMD_CONV_READ) ? idx_q + 2'h1 : idx_q;
  // Byte position register
  always_ff @(posedge i_clk) idx_q <= i_srst ? 2'h0 : idx_d;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  rst_values_a: assert property ($fell(i_srst) |-> o_irq_out_n &&
    o_irq_status == 3'h0 && o_cmd_ready && !o_rsp_valid && !o_tx_start)
    else $error("state after shutdown wrong");
  pin_sel_a: assert property (take && idx_q == 2'h1 |=>
    o_pin_select == $past(i_cmd_byte[1:0])) else $error("pin select wrong");
  att_cfg_a: assert property (
    take && idx_q == 2'h2 && i_cmd_byte != 8'h00
    |=> o_pin_input_attenuation == $past(i_cmd_byte[3:0]))
    else $error("attenuation wrong");
  att_dflt_a: assert property (
    take && idx_q == 2'h2 && i_cmd_byte == 8'h00
    |=> o_pin_input_attenuation == 4'hc)
    else $error("default attenuation wrong");
  hold_off_a: assert property (
    take && idx_q == 2'h2 |=> !o_cmd_ready)
    else $error("command not held off");
  reply_busy_a: assert property (o_rsp_valid |-> !o_cmd_ready)
    else $error("command taken during reply");
  rsp_hold_a: assert property (o_rsp_valid && !i_rsp_ready |=>
    o_rsp_valid && $stable(o_rsp_byte)) else $error("reply byte moved");
  cts_first_a: assert property ($rose(o_rsp_valid) |->
    o_rsp_byte == AUX_CTS_READY) else $error("first byte not ready code");
  tx_mode_a: assert property (o_tx_start |-> i_wake_enable &&
    i_duty_mode == AUX_DUTY_TX) else $error("send outside duty mode");
  sent_irq_a: assert property (i_tx_done && i_irq_en_sent |=>
    !o_irq_out_n && o_irq_status[0]) else $error("sent irq missing");
  back_wake_a: assert property (i_tx_done && i_wake_enable |=>
    o_in_wake_state) else $error("no return to wake state");
  irq_cause_a: assert property (!o_irq_out_n |-> o_irq_status != 3'h0)
    else $error("irq low without cause");
endmodule

bind aux_top aux_top_asserts u_chk (.i_clk(i_clk), .i_srst(i_srst),
  .i_duty_mode(i_duty_mode), .i_wake_enable(i_wake_enable),
  .i_irq_en_sent(i_irq_en_sent), .i_tx_done(i_tx_done),
  .i_cmd_valid(i_cmd_valid), .i_cmd_byte(i_cmd_byte),
  .i_rsp_ready(i_rsp_ready), .o_cmd_ready(o_cmd_ready),
  .o_rsp_valid(o_rsp_valid), .o_rsp_byte(o_rsp_byte),
  .o_tx_start(o_tx_start), .o_pin_select(o_pin_select),
  .o_pin_input_attenuation(o_pin_input_attenuation),
  .o_irq_out_n(o_irq_out_n), .o_irq_status(o_irq_status),
  .o_in_wake_state(o_in_wake_state));

// ---- sim/aux_host.sv ----
// Host model: sends command bytes, reads reply with random stalls
module aux_host (
  // Clock
  input  wire logic       i_clk,
  // Command stream
  output logic            o_valid,
  output logic [7:0]      o_byte,
  input  wire logic       i_ready,
  // Reply stream
  input  wire logic       i_rvalid,
  input  wire logic [7:0] i_rbyte,
  output logic            o_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle at time zero
  initial begin
    o_valid = 1'b0;
    o_byte = 8'h00;
    o_rready = 1'b0;
  end
  // Command, enable, config back to back; valid held across
  task automatic cmd(input logic [23:0] w);
    for (int i = 0; i < 3; i++) begin
      o_valid <= 1'b1;
      o_byte <= w[23 - 8 * i -: 8];
      do @(posedge i_clk); while (i_ready !== 1'b1);
    end
    o_valid <= 1'b0;
    o_byte <= ~w[7:0]; // Released line shows junk, not the last byte
  endtask
  // Nine reply bytes; ready toggles at random to stall the device
  task automatic get(output logic [71:0] r);
    int n;
    n = 0;
    r = '0;
    while (n < 9) begin
      o_rready <= 1'($urandom_range(1));
      @(posedge i_clk);
      if (o_rready && i_rvalid === 1'b1) begin
        r = {r[63:0], i_rbyte};
        n++;
      end
    end
    o_rready <= 1'b0;
  endtask
endmodule

// ---- sim/tb.sv ----
module tb
  import aux_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Bench signals
  logic        clk, srst, wen, lsen, lspin, en_s, en_w, en_l, clr;
  logic        cv, cr, rv, rr, txs, irqn, lpin, inw;
  logic        tick = 1'b0;
  logic        txd  = 1'b0;
  logic [1:0]  dmode, psel;
  logic [3:0]  att;
  logic [4:0]  wexp, thr;
  logic [2:0]  st;
  logic [7:0]  cb, rbyte;
  logic [7:0]  txsh = 8'h00;
  logic [15:0] wman, dcnt, rp, rb, rt;
  logic [3:0]  atts [5] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'hc};
  int          n_errors, cmp_count, ticks, tcnt, t0, t1;

  always #50 clk = ~clk;
  // 32 kHz tick every 305 clocks; transmit path answers 9 clocks late
  always @(posedge clk) begin
    tcnt <= (tcnt == 304) ? 0 : tcnt + 1;
    tick <= (tcnt == 304);
    ticks <= ticks + int'(tick);
    txsh <= {txsh[6:0], txs === 1'b1};
    txd <= txsh[7];
  end

  aux_top u_dut (.i_clk(clk), .i_srst(srst), .i_tick_32k(tick),
    .i_wake_enable(wen), .i_low_supply_check_en(lsen), .i_duty_mode(dmode),
    .i_wake_exponent(wexp), .i_wake_mantissa(wman),
    .i_duty_interval_count(dcnt), .i_low_supply_threshold(thr),
    .i_low_supply_to_pin(lspin), .i_irq_en_sent(en_s), .i_irq_en_wake(en_w),
    .i_irq_en_low_supply(en_l), .i_irq_status_clear(clr),
    .o_tx_start(txs), .i_tx_done(txd), .i_cmd_valid(cv), .i_cmd_byte(cb),
    .o_cmd_ready(cr), .o_rsp_valid(rv), .o_rsp_byte(rbyte),
    .i_rsp_ready(rr), .i_raw_pin(rp), .i_raw_batt(rb), .i_raw_temp(rt),
    .o_pin_select(psel), .o_pin_input_attenuation(att),
    .o_irq_out_n(irqn), .o_low_supply_pin(lpin), .o_irq_status(st),
    .o_in_wake_state(inw));
  aux_host u_host (.i_clk(clk), .o_valid(cv), .o_byte(cb), .i_ready(cr),
    .i_rvalid(rv), .i_rbyte(rbyte), .o_rready(rr));

  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic conclude();
    $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // One read command against the reference reply and latency
  task automatic conv(input logic [7:0] en, input logic [7:0] cfg);
    logic [71:0] r;
    logic [15:0] p, b, t;
    logic [3:0]  ue;
    int          n, lim;
    rp <= 16'($urandom);
    rb <= 16'($urandom);
    rt <= 16'($urandom);
    repeat (4) @(posedge clk);
    p = en[2] ? rp : 16'h0000;
    b = en[3] ? rb : 16'h0000;
    t = en[4] ? rt : 16'h0000;
    ue = (cfg == 8'h00) ? 4'hc : cfg[7:4];
    lim = 3 + (int'(en[2]) + int'(en[3]) + int'(en[4])) * 12 * (2 << ue);
    u_host.cmd({AUX_CMD_CONV_READ, en, cfg});
    n = 0;
    while (rv !== 1'b1 && n < lim + 9) begin
      @(posedge clk);
      n++;
    end
    chk(n >= lim - 1 && n <= lim + 1, "reply latency");
    u_host.get(r);
    chk(r === {AUX_CTS_READY, p, b, t, 16'h0000}, "reply");
    chk(psel === en[1:0], "pin select");
    chk(att === ((cfg == 8'h00) ? 4'hc : cfg[3:0]), "attenuation");
  endtask
  task automatic clear();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
  endtask
  // Bounded wait for one send request; tick count at that moment
  task automatic wait_tx(output int tk);
    int n;
    n = 0;
    while (txs !== 1'b1 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    tk = ticks;
    chk(n < 30000, "send timeout");
    @(posedge clk);
  endtask
  // Clear status, then bounded wait for the next wake expiry
  task automatic wait_wake();
    int n;
    clear();
    n = 0;
    while (st[1] !== 1'b1 && n < 30000) begin
      @(posedge clk);
      n++;
    end
    chk(n < 30000, "wake timeout");
    repeat (4) @(posedge clk);
  endtask
  // Expected supply comparison result, millivolt arithmetic
  function automatic bit low();
    return (int'(rb) * 3000 / 1280) < (1500 + 50 * int'(thr));
  endfunction

  initial begin
    // Tests take about 40k clocks; allow 60k
    #6000000;
    n_errors++;
    conclude();
  end
  initial begin
    {clk, wen, lsen, lspin, en_s, en_w, en_l, clr} = '0;
    {dmode, wexp, thr, wman, dcnt, rp, rb, rt} = '0;
    srst = 1'b1;
    void'($urandom(22));
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      conv({3'h0, 3'(i), 2'($urandom)}, {4'(i % 2), atts[i % 5]});
    end
    conv(8'h00, 8'h00);
    $display("converter test done");
    // Duty mode: three sends, interval count 2, exponent 1
    wexp <= 5'h01;
    dcnt <= 16'h0002;
    wman <= 16'h0100;
    dmode <= AUX_DUTY_TX;
    en_s <= 1'b1;
    wen <= 1'b1;
    wait_tx(t0);
    wait_tx(t1);
    chk(t1 - t0 >= 15 && t1 - t0 <= 17, "duty period");
    repeat (12) @(posedge clk);
    chk(irqn === 1'b0 && st[0] === 1'b1, "sent irq");
    chk(inw === 1'b1, "wake state");
    clear();
    en_s <= 1'b0;
    wait_tx(t0);
    repeat (12) @(posedge clk);
    chk(irqn === 1'b1, "masked sent irq");
    wen <= 1'b0;
    dmode <= 2'h0;
    $display("duty test done");
    // Wake expiry every 12 ticks with supply check at 2000 mV
    wexp <= 5'h00;
    wman <= 16'h0003;
    thr <= 5'h0a;
    rb <= 16'd800;
    lsen <= 1'b1;
    en_l <= 1'b1;
    clear();
    t0 = ticks;
    wen <= 1'b1;
    wait_wake();
    chk(ticks - t0 >= 11 && ticks - t0 <= 14, "wake period");
    chk(st[2] === 1'(low()) && irqn === 1'b0, "low irq");
    lspin <= 1'b1;
    wait_wake();
    chk(lpin === 1'(low()) && st[2] === 1'b0, "low pin");
    rb <= 16'd1000;
    wait_wake();
    chk(lpin === 1'(low()) && irqn === 1'b1, "supply ok");
    en_w <= 1'b1;
    wait_wake();
    chk(irqn === 1'b0, "wake irq");
    wen <= 1'b0;
    clear();
    repeat (4600) @(posedge clk);
    chk(st === 3'h0 && irqn === 1'b1, "timer off");
    $display("wake test done");
    // Shutdown in mid-run with the wake timer active
    wen <= 1'b1;
    wait_wake();
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(irqn === 1'b1 && st === 3'h0 && cr === 1'b1, "shutdown");
    srst <= 1'b0;
    conv(8'h04, 8'h10);
    $display("shutdown test done");
    conclude();
  end
endmodule
